// *** rtl/ff_cells_pkg.sv ***
// Purpose: Shared constants for the storage cell library
// Assumes: One clock, synchronous active-high reset
// Notes:   Reset value applies to every clocked cell
package ff_cells_pkg;
   localparam logic CELL_RESET_VALUE = 1'b0;
   localparam int   JK_GROUP_WIDTH   = 2;
   typedef enum logic [1:0] {
      SR_HOLD  = 2'b00,
      SR_SET   = 2'b01,
      SR_RESET = 2'b10,
      SR_BOTH  = 2'b11
   } sr_cmd_t;
endpackage

// *** rtl/flip_flop_type_cells.sv ***
// Purpose: Library of one-bit storage cells: latch, clocked set/reset, J-K, D, toggles
// Assumes: All clocked cells share REF_CLK_IN; inputs synchronous to it
// Notes:   Latch is combinational feedback by intent; keep it out of timing paths
// Behaviour
// - Latch follows set/reset with no clock
// - Clocked set/reset updates only at clock edge
// - Strapped inputs make set/reset cell toggle
// - Set/reset cell inputs are active low
// - J-K holds, sets, resets like set/reset
// - J-K inverts when J and K asserted
// - J-K has several and inverted inputs
// - D cell loads data at clock edge
// - Toggle with enable inverts only when enabled
// - Clock-only toggle inverts every clock edge
// - D cell built from set/reset plus NAND
`timescale 1ns/100ps
module flip_flop_type_cells
   import ff_cells_pkg::*;
#(
   parameter int JK_WIDTH = ff_cells_pkg::JK_GROUP_WIDTH
) (
   input  wire logic                REF_CLK_IN,
   input  wire logic                SYS_RST_IN,
   input  wire logic                LATCH_SET_IN,
   input  wire logic                LATCH_RESET_IN,
   output logic                     LATCH_Q_OUT,
   input  wire logic                SR_SET_N_IN,
   input  wire logic                SR_RESET_N_IN,
   output logic                     SR_Q_OUT,
   output logic                     SR_Q_N_OUT,
   input  wire logic [JK_WIDTH-1:0] JK_J_IN,
   input  wire logic [JK_WIDTH-1:0] JK_K_IN,
   input  wire logic                JK_J_N_IN,
   input  wire logic                JK_K_N_IN,
   output logic                     JK_Q_OUT,
   input  wire logic                D_DATA_IN,
   output logic                     D_Q_OUT,
   input  wire logic                T_ENABLE_IN,
   output logic                     T_Q_OUT,
   output logic                     T_FREE_Q_OUT,
   input  wire logic                DSR_DATA_IN,
   output logic                     DSR_Q_OUT
);
   import ff_cells_pkg::*;

   logic latch_q;
   logic sr_q, next_sr_q;
   logic sr_q_n, next_sr_q_n;
   logic jk_q, next_jk_q;
   logic d_q, next_d_q;
   logic t_q, next_t_q;
   logic tf_q, next_tf_q;
   logic dsr_q, next_dsr_q;
   logic jk_j_act, jk_k_act;
   logic dsr_set_n, dsr_reset_n;
   sr_cmd_t sr_cmd, dsr_cmd;

   // Level-sensitive always_latch; reset wins when both are driven
   always_latch begin
      if (LATCH_RESET_IN) begin
         latch_q = 1'b0;
      end else if (LATCH_SET_IN) begin
         latch_q = 1'b1;
      end
   end
   assign LATCH_Q_OUT = latch_q;

   // Shared next-state function of the clocked set/reset cell
   function automatic logic sr_next(input sr_cmd_t cmd, input logic q);
      logic n;
      n = q;
      case (cmd)
         SR_SET:   n = 1'b1;
         SR_RESET: n = 1'b0;
         // Both asserted is undefined; holding is the safe pick
         default:  n = q;
      endcase
      return n;
   endfunction

   // Toggle strap: set_n tied to q, reset_n tied to q_n, logic unchanged
   assign sr_cmd = sr_cmd_t'({~SR_RESET_N_IN, ~SR_SET_N_IN});
   // D from set/reset: data drives reset_n, NAND of it drives set_n
   assign dsr_reset_n = DSR_DATA_IN;
   assign dsr_set_n   = ~(DSR_DATA_IN & dsr_reset_n);
   assign dsr_cmd     = sr_cmd_t'({~dsr_reset_n, ~dsr_set_n});

   assign jk_j_act = (&JK_J_IN) & ~JK_J_N_IN;
   assign jk_k_act = (&JK_K_IN) & ~JK_K_N_IN;

   // Inverse is its own flop so both outputs switch on the same edge
   always_comb begin
      next_sr_q   = sr_next(sr_cmd, sr_q);
      next_sr_q_n = ~next_sr_q;
   end

   // State only moves in the flop groups, so every cell except the latch holds between edges
   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         sr_q   <= CELL_RESET_VALUE;
         sr_q_n <= ~CELL_RESET_VALUE;
      end else begin
         sr_q   <= next_sr_q;
         sr_q_n <= next_sr_q_n;
      end
   end

   always_comb begin
      next_dsr_q = sr_next(dsr_cmd, dsr_q);
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         dsr_q <= CELL_RESET_VALUE;
      end else begin
         dsr_q <= next_dsr_q;
      end
   end

   always_comb begin
      case ({jk_j_act, jk_k_act})
         2'b10:   next_jk_q = 1'b1;
         2'b01:   next_jk_q = 1'b0;
         2'b11:   next_jk_q = ~jk_q;
         default: next_jk_q = jk_q;
      endcase
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         jk_q <= CELL_RESET_VALUE;
      end else begin
         jk_q <= next_jk_q;
      end
   end

   always_comb begin
      next_d_q = D_DATA_IN;
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         d_q <= CELL_RESET_VALUE;
      end else begin
         d_q <= next_d_q;
      end
   end

   always_comb begin
      next_t_q = T_ENABLE_IN ? ~t_q : t_q;
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         t_q <= CELL_RESET_VALUE;
      end else begin
         t_q <= next_t_q;
      end
   end

   always_comb begin
      next_tf_q = ~tf_q;
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         tf_q <= CELL_RESET_VALUE;
      end else begin
         tf_q <= next_tf_q;
      end
   end

   assign SR_Q_OUT     = sr_q;
   assign SR_Q_N_OUT   = sr_q_n;
   assign JK_Q_OUT     = jk_q;
   assign D_Q_OUT      = d_q;
   assign T_Q_OUT      = t_q;
   assign T_FREE_Q_OUT = tf_q;
   assign DSR_Q_OUT    = dsr_q;

   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   chk_latch_set_now: assert property (LATCH_SET_IN && !LATCH_RESET_IN |-> LATCH_Q_OUT)
      else $error("Latch did not set");
   chk_sr_low_set: assert property (!SR_SET_N_IN && SR_RESET_N_IN |=> SR_Q_OUT)
      else $error("Active-low set failed");
   chk_sr_low_reset: assert property (SR_SET_N_IN && !SR_RESET_N_IN |=> !SR_Q_OUT)
      else $error("Active-low reset failed");
   chk_sr_strap_toggle: assert property (SR_SET_N_IN == SR_Q_OUT && SR_RESET_N_IN == SR_Q_N_OUT
      |=> SR_Q_OUT != $past(SR_Q_OUT))
      else $error("Strapped cell did not toggle");
   chk_sr_hold_idle: assert property (SR_SET_N_IN && SR_RESET_N_IN |=> $stable(SR_Q_OUT))
      else $error("Set/reset cell changed while idle");
   chk_jk_modes: assert property (jk_j_act != jk_k_act |=> JK_Q_OUT == $past(jk_j_act))
      else $error("J-K set or reset wrong");
   chk_jk_hold: assert property (!jk_j_act && !jk_k_act |=> $stable(JK_Q_OUT))
      else $error("J-K did not hold");
   chk_jk_toggle: assert property (jk_j_act && jk_k_act |=> JK_Q_OUT != $past(JK_Q_OUT))
      else $error("J-K did not invert");
   chk_jk_and_group: assert property (!(&JK_J_IN) && !JK_K_N_IN && (&JK_K_IN) |=> !JK_Q_OUT)
      else $error("Partial J group acted");
   chk_jk_inv_input: assert property (JK_J_N_IN && (&JK_J_IN) && !(&JK_K_IN) |=> $stable(JK_Q_OUT))
      else $error("Inverted J input ignored");
   chk_d_load: assert property (1'b1 |=> D_Q_OUT == $past(D_DATA_IN))
      else $error("D cell did not load");
   chk_t_enable: assert property (T_ENABLE_IN |=> T_Q_OUT != $past(T_Q_OUT))
      else $error("Enabled toggle missed");
   chk_t_disabled: assert property (!T_ENABLE_IN |=> $stable(T_Q_OUT))
      else $error("Disabled toggle moved");
   chk_t_free_run: assert property (T_FREE_Q_OUT |=> !T_FREE_Q_OUT ##1 T_FREE_Q_OUT)
      else $error("Free toggle missed an edge");
   chk_dsr_follows: assert property (1'b1 |=> DSR_Q_OUT == $past(DSR_DATA_IN))
      else $error("Derived D cell wrong");
   chk_latch_reset_wins: assert property (LATCH_RESET_IN |-> !LATCH_Q_OUT)
      else $error("Latch reset did not dominate");
   chk_sr_out_pair: assert property (SR_Q_N_OUT == !SR_Q_OUT)
      else $error("Set/reset outputs not complementary");
   chk_jk_inv_k_block: assert property (JK_K_N_IN && (&JK_K_IN) && (&JK_J_IN) && !JK_J_N_IN
      |=> JK_Q_OUT)
      else $error("Inverted K input ignored");

   cov_jk_toggle: cover property (jk_j_act && jk_k_act ##1 jk_j_act && jk_k_act);
   cov_sr_strap: cover property (SR_SET_N_IN == SR_Q_OUT && SR_RESET_N_IN == SR_Q_N_OUT);
   cov_t_enable_run: cover property (T_ENABLE_IN [*3]);
   cov_dsr_rise: cover property (!DSR_Q_OUT ##1 DSR_Q_OUT);
   cov_jk_k_blocked: cover property (JK_K_N_IN && (&JK_K_IN) && (&JK_J_IN) && !JK_J_N_IN);
endmodule // flip_flop_type_cells

// *** bench/test_flip_flop_type_cells.sv ***
// Purpose: Self-checking bench for the storage cell library
// Assumes: Inputs change 1 ns after the rising edge; model runs on the same edge
// Notes:   Random inputs with a strapped-toggle stretch, a forced J-K toggle run and a mid-run reset
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
   $display("Error %0t %h %h", $time, g, e); end end
module test_flip_flop_type_cells;
   import ff_cells_pkg::*;
   logic        clk = 1'h0, rst = 1'h1, ls = 1'h0, lr = 1'h1, sn = 1'h1, rn = 1'h1, jn = 1'h1, kn = 1'h1;
   logic        d = 1'h0, te = 1'h0, dsr = 1'h0;
   logic [1:0]  jj = 2'h0, kk = 2'h0;
   logic        lq, sq, sqn, jq, dq, tq, fq, rq;
   logic        e_l = 1'h0, e_s = 1'h0, e_j = 1'h0, e_d = 1'h0, e_t = 1'h0, e_f = 1'h0, e_r = 1'h0;
   logic [31:0] seed = 32'h0000005E;
   int          err_total = 0;
   int          compares = 0;

   always #5 clk = ~clk;

   flip_flop_type_cells dut_u (
      .REF_CLK_IN(clk), .SYS_RST_IN(rst), .LATCH_SET_IN(ls), .LATCH_RESET_IN(lr), .LATCH_Q_OUT(lq),
      .SR_SET_N_IN(sn), .SR_RESET_N_IN(rn), .SR_Q_OUT(sq), .SR_Q_N_OUT(sqn), .JK_J_IN(jj), .JK_K_IN(kk),
      .JK_J_N_IN(jn), .JK_K_N_IN(kn), .JK_Q_OUT(jq), .D_DATA_IN(d), .D_Q_OUT(dq), .T_ENABLE_IN(te),
      .T_Q_OUT(tq), .T_FREE_Q_OUT(fq), .DSR_DATA_IN(dsr), .DSR_Q_OUT(rq));

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Both asserted keeps the state, as the design chose
   function automatic logic sr_next(input logic q, input logic s, input logic r);
      return (s & ~r) ? 1'h1 : ((r & ~s) ? 1'h0 : q);
   endfunction

   task automatic tally_and_finish();
      if (err_total == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clk);
      #1 rst = 1'h0;
      for (int i = 0; i < 600; i++) begin
         @(posedge clk);
         // Reset clears every clocked cell but leaves the latch alone
         if (rst) begin
            {e_s, e_j, e_d, e_t, e_f, e_r} = {6{CELL_RESET_VALUE}};
         end
         else begin
            e_s = sr_next(e_s, ~sn, ~rn);
            e_j = (&jj & ~jn & &kk & ~kn) ? ~e_j : sr_next(e_j, &jj & ~jn, &kk & ~kn);
            e_d = d;
            e_t = e_t ^ te;
            e_f = ~e_f;
            e_r = dsr;
         end
         #1;
         rst = (i == 450) || (i == 451);
         seed = xs(seed);
         {ls, lr, jj, kk, jn, kn, d, te, dsr} = seed[10:0];
         // Back-to-back J-K toggles right after reset
         if (i < 8) {jj, kk, jn, kn} = 6'h3C;
         if (i >= 300 && i < 340) begin
            sn = sq;
            rn = sqn;
         end
         else begin
            sn = seed[12];
            rn = seed[13] | ~seed[12];
         end
         #1;
         e_l = lr ? 1'h0 : (ls ? 1'h1 : e_l);
         // Inputs already moved, so clocked outputs must still show the edge value
         `CHK(lq, e_l)
         `CHK({sq, sqn}, {e_s, ~e_s})
         `CHK(jq, e_j)
         `CHK({dq, rq}, {e_d, e_r})
         `CHK({tq, fq}, {e_t, e_f})
      end
      tally_and_finish();
   end

   initial begin
      #20000;
      err_total++;
      tally_and_finish();
   end
endmodule // test_flip_flop_type_cells
